// ### logic/sbce_engine.sv
`timescale 1ns/1ps
`include "sbce_defines.svh"
module sbce_engine
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// command pins, sampled on the rising edge
	input wire logic clk_gate,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic [1:0] bank_select,
	input wire logic [12:0] addr,
	input wire logic [1:0] byte_mask,
	// data pins
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic [1:0] dq_oe_n,
	// array port
	output logic [1:0] arr_bank,
	output logic [12:0] arr_row,
	output logic [8:0] arr_col,
	output logic arr_write,
	output logic [15:0] arr_wdata,
	output logic [1:0] arr_wmask,
	input wire logic [15:0] arr_rdata,
	// status
	output logic [1:0] pwr_state,
	output logic [3:0] bank_open,
	output logic illegal_cmd
);
	import sbce_pkg::*;

	localparam int ROW_CYCLE_TIME = `SBCE_ROW_CYCLE_CYC;
	localparam int PRECHARGE_TIME = `SBCE_PRECHARGE_CYC;
	localparam int ROW_TO_COL_DELAY = `SBCE_ROW_TO_COL_CYC;
	localparam int WRITE_RECOVERY_TIME = `SBCE_WRITE_RECOVERY_CYC;
	localparam int ACT_TO_ACT_DELAY = `SBCE_ACT_TO_ACT_CYC;
	localparam int MODE_SET_CYCLE_TIME = `SBCE_MODE_SET_CYC;

	// ----------------------------------------------------------------
	// input synchronisers (pins are outside this clock domain)
	// ----------------------------------------------------------------
	logic [37:0] pin_s1_q;
	logic [37:0] pin_s2_q;
	// idle levels at reset: zeros would show a gate fall and drop into power down
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			pin_s1_q <= `SBCE_PIN_IDLE;
			pin_s2_q <= `SBCE_PIN_IDLE;
		end
		else
		begin
			pin_s1_q <= {clk_gate, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
				bank_select, addr, byte_mask, dq_in};
			pin_s2_q <= pin_s1_q;
		end
	end
	logic gate;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic [12:0] a;
	logic [1:0] dqm;
	logic [15:0] din;
	assign {gate, cs_n, ras_n, cas_n, we_n, ba, a, dqm, din} = pin_s2_q;

	// command decode from strobe levels
	function automatic sbce_cmd_t decode(input logic c, input logic r, input logic k,
		input logic w);
		sbce_cmd_t res;
		res = SBCE_CMD_NOP;
		if (c)
			res = SBCE_CMD_DESELECT_CMD;
		else
			case ({r, k, w})
				3'h3: res = SBCE_CMD_ACT;
				3'h5: res = SBCE_CMD_READ;
				3'h4: res = SBCE_CMD_WRITE;
				3'h2: res = SBCE_CMD_PRE;
				3'h1: res = SBCE_CMD_REF;
				3'h0: res = SBCE_CMD_MODE;
				3'h6: res = SBCE_CMD_STOP;
				default: res = SBCE_CMD_NOP;
			endcase
		return res;
	endfunction
	sbce_cmd_t cmd;
	assign cmd = decode(cs_n, ras_n, cas_n, we_n);

	// ----------------------------------------------------------------
	// clock gate and power state
	// ----------------------------------------------------------------
	logic gate_prev_q;
	sbce_pwr_t pwr_q;
	logic [7:0] exit_cnt_q;
	logic [3:0] bank_busy;
	logic all_idle;
	logic suspend_q;
	logic live;
	assign all_idle = (bank_busy == 4'h0);
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			gate_prev_q <= 1'b1;
		else
			gate_prev_q <= gate;
	end
	// suspension starts and ends one cycle after the gate moves
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			suspend_q <= 1'b0;
		else if (pwr_q == SBCE_PWR_NORMAL && !all_idle)
			suspend_q <= !gate;
		else
			suspend_q <= 1'b0;
	end
	assign live = gate_prev_q && !suspend_q && (pwr_q == SBCE_PWR_NORMAL);

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			pwr_q <= SBCE_PWR_NORMAL;
			exit_cnt_q <= 8'h0;
		end
		else
			case (pwr_q)
				SBCE_PWR_NORMAL:
					if (gate_prev_q && !gate && all_idle)
						pwr_q <= (cmd == SBCE_CMD_REF) ? SBCE_PWR_SELF_REFRESH
							: SBCE_PWR_POWER_DOWN;
				SBCE_PWR_SELF_REFRESH:
					if (gate)
					begin
						pwr_q <= SBCE_PWR_EXITING;
						exit_cnt_q <= 8'(ROW_CYCLE_TIME);
					end
				SBCE_PWR_POWER_DOWN:
					if (gate)
						pwr_q <= SBCE_PWR_NORMAL;
				SBCE_PWR_EXITING:
					if (exit_cnt_q <= 8'h1)
						pwr_q <= SBCE_PWR_NORMAL;
					else
						exit_cnt_q <= exit_cnt_q - 8'h1;
				default: pwr_q <= SBCE_PWR_NORMAL;
			endcase
	end

	// ----------------------------------------------------------------
	// mode register
	// ----------------------------------------------------------------
	logic [6:0] mode_q;
	logic [7:0] mode_wait_q;
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			mode_q <= `SBCE_MODE_RESET;
			mode_wait_q <= 8'h0;
		end
		else if (live && gate && cmd == SBCE_CMD_MODE && all_idle)
		begin
			mode_q <= a[6:0];
			mode_wait_q <= 8'(MODE_SET_CYCLE_TIME);
		end
		else if (mode_wait_q != 8'h0)
			mode_wait_q <= mode_wait_q - 8'h1;
	end
	logic [2:0] bl_code;
	logic interleave;
	logic [2:0] cas_lat;
	logic page_mode;
	logic [8:0] bl_len;
	assign bl_code = mode_q[`SBCE_MODE_BL_LSB +: 3];
	assign interleave = mode_q[`SBCE_MODE_BT_BIT];
	assign cas_lat = mode_q[`SBCE_MODE_CL_LSB +: 3];
	assign page_mode = (bl_code == `SBCE_BL_PAGE) && !interleave;
	assign bl_len = page_mode ? 9'h000 : (bl_code == `SBCE_BL_8) ? 9'h008
		: (bl_code == `SBCE_BL_4) ? 9'h004 : (bl_code == `SBCE_BL_2) ? 9'h002 : 9'h001;

	// ----------------------------------------------------------------
	// command acceptance
	// ----------------------------------------------------------------
	logic go;
	assign go = live && gate_prev_q && (mode_wait_q == 8'h0);
	logic [7:0] rrd_q;
	sbce_bank_t bst_q [4];
	logic [7:0] bcnt_q [4];
	logic [3:0] bap_q;
	logic [12:0] row_q [4];

	// burst column sequencing
	function automatic logic [8:0] next_col(input logic [8:0] start, input logic [8:0] beat,
		input logic [2:0] code, input logic ilv, input logic pg);
		logic [8:0] m;
		logic [8:0] off;
		m = (code == `SBCE_BL_8) ? 9'h007 : (code == `SBCE_BL_4) ? 9'h003
			: (code == `SBCE_BL_2) ? 9'h001 : 9'h000;
		off = ilv ? ((start ^ beat) & m) : ((start + beat) & m);
		return pg ? 9'(start + beat) : ((start & ~m) | off);
	endfunction

	// ----------------------------------------------------------------
	// burst engine (one burst at a time on the data bus)
	// ----------------------------------------------------------------
	logic burst_rd_q;
	logic burst_wr_q;
	logic [1:0] burst_bank_q;
	logic [8:0] burst_start_q;
	logic [8:0] burst_beat_q;
	logic [3:0] stop_cnt_q;
	logic new_rd;
	logic new_wr;
	logic bank_ok;
	assign bank_ok = (bst_q[ba] == SBCE_BANK_ACTIVE || bst_q[ba] == SBCE_BANK_READING
		|| bst_q[ba] == SBCE_BANK_WRITING) && !bap_q[ba];
	assign new_rd = go && cmd == SBCE_CMD_READ && bank_ok
		&& !(page_mode && a[`SBCE_AUTOCLOSE_BIT]);
	assign new_wr = go && cmd == SBCE_CMD_WRITE && bank_ok
		&& !(page_mode && a[`SBCE_AUTOCLOSE_BIT]);
	logic cut_read;
	assign cut_read = go && burst_rd_q && (cmd == SBCE_CMD_STOP
		|| (cmd == SBCE_CMD_PRE && (a[`SBCE_AUTOCLOSE_BIT] || ba == burst_bank_q)));

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			burst_rd_q <= 1'b0;
			burst_wr_q <= 1'b0;
			burst_bank_q <= 2'h0;
			burst_start_q <= 9'h0;
			burst_beat_q <= 9'h0;
		end
		else if (new_rd || new_wr)
		begin
			burst_rd_q <= new_rd && (bl_len != 9'h001);
			burst_wr_q <= new_wr && (bl_len != 9'h001);
			burst_bank_q <= ba;
			burst_start_q <= a[8:0];
			burst_beat_q <= 9'h1;
		end
		else if (go && (cmd == SBCE_CMD_STOP || cmd == SBCE_CMD_PRE) && burst_wr_q)
			burst_wr_q <= 1'b0;
		else if (burst_rd_q || burst_wr_q)
		begin
			burst_beat_q <= burst_beat_q + 9'h1;
			if (!page_mode && burst_beat_q + 9'h1 >= bl_len)
			begin
				burst_rd_q <= 1'b0;
				burst_wr_q <= 1'b0;
			end
		end
	end

	// array access: writes take the first word with the command
	logic [8:0] col_now;
	assign col_now = next_col(burst_start_q, burst_beat_q, bl_code, interleave, page_mode);
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			arr_bank <= 2'h0;
			arr_row <= 13'h0;
			arr_col <= 9'h0;
			arr_write <= 1'b0;
			arr_wdata <= 16'h0;
			arr_wmask <= 2'h3;
		end
		else
		begin
			arr_bank <= (new_rd || new_wr) ? ba : burst_bank_q;
			arr_row <= row_q[(new_rd || new_wr) ? ba : burst_bank_q];
			arr_col <= (new_rd || new_wr) ? a[8:0] : col_now;
			arr_write <= new_wr || (burst_wr_q && live && !new_rd);
			arr_wdata <= din;
			arr_wmask <= dqm; // write mask with zero latency
		end
	end

	// read pipeline: column latency, mask two cycles, cut after latency
	logic [7:0] rd_valid_q;
	logic [1:0] dqm_d1_q;
	logic [1:0] dqm_d2_q;
	logic wr_cut_q;
	logic [1:0] wr_cut_d_q;
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			rd_valid_q <= 8'h0;
			stop_cnt_q <= 4'h0;
			dqm_d1_q <= 2'h3;
			dqm_d2_q <= 2'h3;
			wr_cut_d_q <= 2'h0;
		end
		else
		begin
			rd_valid_q <= {rd_valid_q[6:0], new_rd || (burst_rd_q && !cut_read && !new_wr)};
			stop_cnt_q <= cut_read ? 4'({1'b0, cas_lat}) : (stop_cnt_q != 4'h0)
				? stop_cnt_q - 4'h1 : 4'h0;
			dqm_d1_q <= dqm;
			dqm_d2_q <= dqm_d1_q;
			wr_cut_d_q <= {wr_cut_d_q[0], new_wr};
		end
	end
	assign wr_cut_q = wr_cut_d_q[1];
	logic rd_drive;
	// the output stage adds one cycle, so tap one short; latency one is not supported
	assign rd_drive = rd_valid_q[cas_lat - 3'h2] && !wr_cut_q && stop_cnt_q != 4'h1;
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			dq_out <= 16'h0;
			dq_oe_n <= 2'h3;
		end
		else
		begin
			dq_out <= arr_rdata;
			dq_oe_n <= rd_drive ? dqm_d1_q : 2'h3;
		end
	end

	// ----------------------------------------------------------------
	// per-bank state machines
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rrd_q <= 8'h0;
		else if (go && cmd == SBCE_CMD_ACT && rrd_q == 8'h0 && bst_q[ba] == SBCE_BANK_IDLE)
			rrd_q <= 8'(ACT_TO_ACT_DELAY - 1);
		else if (rrd_q != 8'h0)
			rrd_q <= rrd_q - 8'h1;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_bank
			logic sel;
			logic burst_here;
			assign sel = (ba == 2'(g));
			assign burst_here = (burst_rd_q || burst_wr_q) && burst_bank_q == 2'(g);
			assign bank_busy[g] = (bst_q[g] != SBCE_BANK_IDLE);
			assign bank_open[g] = (bst_q[g] != SBCE_BANK_IDLE
				&& bst_q[g] != SBCE_BANK_PRECHARGING);
			always_ff @(posedge mclk or posedge reset)
			begin
				if (reset)
				begin
					bst_q[g] <= SBCE_BANK_IDLE;
					bcnt_q[g] <= 8'h0;
					bap_q[g] <= 1'b0;
					row_q[g] <= 13'h0;
				end
				else
					case (bst_q[g])
						SBCE_BANK_IDLE:
							if (go && cmd == SBCE_CMD_ACT && sel && rrd_q == 8'h0)
							begin
								bst_q[g] <= SBCE_BANK_ACTIVATING;
								row_q[g] <= a;
								bcnt_q[g] <= 8'(ROW_TO_COL_DELAY - 1);
							end
						SBCE_BANK_ACTIVATING:
							if (bcnt_q[g] == 8'h0)
								bst_q[g] <= SBCE_BANK_ACTIVE;
							else
								bcnt_q[g] <= bcnt_q[g] - 8'h1;
						SBCE_BANK_PRECHARGING:
							if (bcnt_q[g] == 8'h0)
							begin
								bst_q[g] <= SBCE_BANK_IDLE;
								bap_q[g] <= 1'b0;
							end
							else
								bcnt_q[g] <= bcnt_q[g] - 8'h1;
						default:
							if (bap_q[g])
							begin
								// internal precharge after burst or recovery
								if (bcnt_q[g] == 8'h0)
								begin
									bst_q[g] <= SBCE_BANK_PRECHARGING;
									bcnt_q[g] <= 8'(PRECHARGE_TIME - 2);
								end
								else
									bcnt_q[g] <= bcnt_q[g] - 8'h1;
							end
							else if (go && cmd == SBCE_CMD_PRE
								&& (sel || a[`SBCE_AUTOCLOSE_BIT]))
							begin
								bst_q[g] <= SBCE_BANK_PRECHARGING;
								bcnt_q[g] <= 8'(PRECHARGE_TIME - 2);
							end
							else if ((new_rd || new_wr) && sel)
							begin
								bst_q[g] <= new_rd ? SBCE_BANK_READING : SBCE_BANK_WRITING;
								bap_q[g] <= a[`SBCE_AUTOCLOSE_BIT];
								bcnt_q[g] <= new_rd ? 8'(bl_len - 9'h1)
									: 8'(bl_len + 9'(WRITE_RECOVERY_TIME) - 9'h2);
							end
							else if (!burst_here)
								bst_q[g] <= SBCE_BANK_ACTIVE;
					endcase
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			illegal_cmd <= 1'b0;
		else
			illegal_cmd <= go && (((cmd == SBCE_CMD_READ || cmd == SBCE_CMD_WRITE) && !bank_ok)
				|| ((cmd == SBCE_CMD_MODE || cmd == SBCE_CMD_REF) && !all_idle)
				|| (cmd == SBCE_CMD_ACT && (bst_q[ba] != SBCE_BANK_IDLE || rrd_q != 8'h0)));
	end
	assign pwr_state = pwr_q;
endmodule

// ### logic/sbce_defines.svh
`ifndef SBCE_DEFINES_SVH
`define SBCE_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SBCE_CLK_NS 10
`define SBCE_ROW_CYCLE_NS 60
`define SBCE_PRECHARGE_NS 15
`define SBCE_ROW_TO_COL_NS 15
`define SBCE_WRITE_RECOVERY_NS 12
`define SBCE_ACT_TO_ACT_NS 12
`define SBCE_MODE_SET_NS 12
`define SBCE_CEIL_CYC(ns) (((ns) + `SBCE_CLK_NS - 1) / `SBCE_CLK_NS)
`define SBCE_ROW_CYCLE_CYC `SBCE_CEIL_CYC(`SBCE_ROW_CYCLE_NS)
`define SBCE_PRECHARGE_CYC `SBCE_CEIL_CYC(`SBCE_PRECHARGE_NS)
`define SBCE_ROW_TO_COL_CYC `SBCE_CEIL_CYC(`SBCE_ROW_TO_COL_NS)
`define SBCE_WRITE_RECOVERY_CYC `SBCE_CEIL_CYC(`SBCE_WRITE_RECOVERY_NS)
`define SBCE_ACT_TO_ACT_CYC `SBCE_CEIL_CYC(`SBCE_ACT_TO_ACT_NS)
`define SBCE_MODE_SET_CYC `SBCE_CEIL_CYC(`SBCE_MODE_SET_NS)

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define SBCE_MODE_BL_LSB 0
`define SBCE_MODE_BT_BIT 3
`define SBCE_MODE_CL_LSB 4
`define SBCE_MODE_RESET 7'h20
`define SBCE_BL_1 3'h0
`define SBCE_BL_2 3'h1
`define SBCE_BL_4 3'h2
`define SBCE_BL_8 3'h3
`define SBCE_BL_PAGE 3'h7
`define SBCE_DQM_LATENCY 2
`define SBCE_AUTOCLOSE_BIT 10
// synchroniser reset: gate, select and strobes high, masks set, so reset looks idle
`define SBCE_PIN_IDLE 38'h3E00030000

`endif

// ### logic/sbce_pkg.sv
package sbce_pkg;
	typedef enum logic [3:0]
	{
		SBCE_CMD_DESELECT_CMD = 4'h0,
		SBCE_CMD_NOP = 4'h1,
		SBCE_CMD_ACT = 4'h2,
		SBCE_CMD_READ = 4'h3,
		SBCE_CMD_WRITE = 4'h4,
		SBCE_CMD_PRE = 4'h5,
		SBCE_CMD_REF = 4'h6,
		SBCE_CMD_MODE = 4'h7,
		SBCE_CMD_STOP = 4'h8
	} sbce_cmd_t;

	typedef enum logic [2:0]
	{
		SBCE_BANK_IDLE = 3'h0,
		SBCE_BANK_ACTIVATING = 3'h1,
		SBCE_BANK_ACTIVE = 3'h2,
		SBCE_BANK_READING = 3'h3,
		SBCE_BANK_WRITING = 3'h4,
		SBCE_BANK_PRECHARGING = 3'h5
	} sbce_bank_t;

	typedef enum logic [1:0]
	{
		SBCE_PWR_NORMAL = 2'h0,
		SBCE_PWR_SELF_REFRESH = 2'h1,
		SBCE_PWR_POWER_DOWN = 2'h2,
		SBCE_PWR_EXITING = 2'h3
	} sbce_pwr_t;
endpackage

// ### testbench/sbce_engine_props.sv
`timescale 1ns/1ps
module sbce_engine_props
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// command pins
	input wire logic clk_gate,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic [12:0] addr,
	input wire logic [1:0] byte_mask,
	input wire logic [15:0] dq_in,
	// outputs
	input wire logic [1:0] dq_oe_n,
	input wire logic arr_write,
	input wire logic [15:0] arr_wdata,
	input wire logic [1:0] arr_wmask,
	input wire logic [1:0] pwr_state,
	input wire logic [3:0] bank_open,
	input wire logic illegal_cmd
);
	import sbce_pkg::*;
	// ----
	// pin decode
	// ----
	logic [2:0] rcw;
	logic sel;
	// only levels here: the sync delay is absorbed by the delay ranges below
	assign rcw = {row_strobe_n, col_strobe_n, write_enable_n};
	assign sel = clk_gate && !chip_select_n && (pwr_state == SBCE_PWR_NORMAL);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	chk_wdata_first: assert property (arr_write |-> arr_wdata == $past(dq_in, 3))
		else $error("write word differs from data pins");
	chk_wmask_zero: assert property (arr_write |-> arr_wmask == $past(byte_mask, 3))
		else $error("write mask latency wrong");
	chk_sr_banks: assert property (pwr_state == SBCE_PWR_SELF_REFRESH |-> !bank_open)
		else $error("self refresh with a bank open");
	chk_sr_hold: assert property (pwr_state == SBCE_PWR_SELF_REFRESH && !clk_gate
		&& !$past(clk_gate) && !$past(clk_gate, 2) |=> pwr_state == SBCE_PWR_SELF_REFRESH)
		else $error("self refresh left with gate low");
	chk_exit_idle: assert property ($rose(pwr_state == SBCE_PWR_EXITING)
		|-> ##[4:10] pwr_state == SBCE_PWR_NORMAL)
		else $error("self refresh exit not idle in time");
	chk_pd_leave: assert property ((pwr_state == SBCE_PWR_POWER_DOWN && clk_gate)
		##1 clk_gate[*3] |-> ##[0:3] pwr_state == SBCE_PWR_NORMAL)
		else $error("power down not left");
	chk_mask_hide: assert property (!dq_oe_n[0]
		|-> !$past(byte_mask[0], 4))
		else $error("masked byte driven");
	chk_rd_refused: assert property ((sel && rcw == 3'h5 && $past(clk_gate) && !bank_open)
		##1 !bank_open ##1 !bank_open |-> ##[0:3] illegal_cmd)
		else $error("read to closed bank not flagged");
	chk_close_all: assert property (sel && rcw == 3'h2 && addr[10] && $past(clk_gate)
		|-> ##[2:6] bank_open == 4'h0)
		else $error("close all left a bank open");
	chk_act_open: assert property (sel && rcw == 3'h3 && $past(clk_gate) && !bank_open
		|-> ##[1:6] bank_open != 4'h0)
		else $error("activate did not open a bank");
endmodule

bind sbce_engine sbce_engine_props u_props
(
	.mclk(mclk), .reset(reset), .clk_gate(clk_gate), .chip_select_n(chip_select_n),
	.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
	.write_enable_n(write_enable_n), .addr(addr), .byte_mask(byte_mask), .dq_in(dq_in),
	.dq_oe_n(dq_oe_n), .arr_write(arr_write), .arr_wdata(arr_wdata),
	.arr_wmask(arr_wmask), .pwr_state(pwr_state), .bank_open(bank_open),
	.illegal_cmd(illegal_cmd)
);

// ### testbench/sbce_ctrl_model.sv
`timescale 1ns/1ps
module sbce_ctrl_model
(
	// clock
	input wire logic mclk,
	// command and data pins
	output logic clk_gate,
	output logic chip_select_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_enable_n,
	output logic [1:0] bank_select,
	output logic [12:0] addr,
	output logic [1:0] byte_mask,
	output logic [15:0] dq_in
);
	// ----
	// controller pins
	// ----
	logic [15:0] wq[$];
	// gate and masks high, nop inputs from time zero
	initial
	begin
		clk_gate = 1'b1;
		chip_select_n = 1'b0;
		{row_strobe_n, col_strobe_n, write_enable_n} = 3'h7;
		bank_select = 2'h0;
		addr = 13'h0;
		byte_mask = 2'h3;
		dq_in = 16'h0;
	end
	// idle cycles alternate no-op and deselect; data toggles so a stale word never looks valid
	task nop(input int n);
		repeat (n)
		begin
			@(posedge mclk);
			{row_strobe_n, col_strobe_n, write_enable_n} <= 3'h7;
			chip_select_n <= ~chip_select_n;
			dq_in <= ~dq_in;
		end
	endtask
	// first burst word with the command, the rest on following cycles
	task cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a, input logic g);
		@(posedge mclk);
		{row_strobe_n, col_strobe_n, write_enable_n} <= rcw;
		bank_select <= b;
		addr <= a;
		chip_select_n <= 1'b0;
		clk_gate <= g;
		dq_in <= (wq.size() > 0) ? wq.pop_front() : ~dq_in;
		while (wq.size() > 0)
		begin
			@(posedge mclk);
			{row_strobe_n, col_strobe_n, write_enable_n} <= 3'h7;
			dq_in <= wq.pop_front();
		end
		nop(1);
	endtask
	task mask(input logic [1:0] m);
		@(posedge mclk);
		byte_mask <= m;
	endtask
endmodule

// ### testbench/sbce_engine_tb_top.sv
`timescale 1ns/1ps
`include "sbce_defines.svh"
module sbce_engine_tb_top;
	import sbce_pkg::*;
	localparam logic [2:0] ACT = 3'h3;
	localparam logic [2:0] RD = 3'h5;
	localparam logic [2:0] WR = 3'h4;
	localparam logic [2:0] PRE = 3'h2;
	localparam logic [2:0] REF = 3'h1;
	localparam logic [2:0] MODE = 3'h0;
	localparam logic [2:0] NOP = 3'h7;
	logic mclk, reset, clk_gate, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
	logic arr_write, illegal_cmd;
	logic [1:0] bank_select, byte_mask, dq_oe_n, arr_bank, arr_wmask, pwr_state, b;
	logic [12:0] addr, arr_row, r;
	logic [8:0] arr_col, s;
	logic [3:0] bank_open;
	logic [15:0] dq_in, dq_out, arr_wdata, arr_rdata, fails, samples_checked, illegal_seen;
	logic [31:0] seed;
	logic [15:0] rd_q[$], wd_q[$], wc_q[$];
	// burst shapes: length code, beats, interleave
	logic [2:0] code_t[5] = '{`SBCE_BL_2, `SBCE_BL_4, `SBCE_BL_8, `SBCE_BL_4, `SBCE_BL_1};
	int bl_t[5] = '{2, 4, 8, 4, 1};
	logic ilv_t[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	// ----
	// design, controller and array stand-in
	// ----
	sbce_engine dut
	(
		.mclk(mclk), .reset(reset), .clk_gate(clk_gate), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_enable_n(write_enable_n), .bank_select(bank_select), .addr(addr),
		.byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col), .arr_write(arr_write),
		.arr_wdata(arr_wdata), .arr_wmask(arr_wmask), .arr_rdata(arr_rdata),
		.pwr_state(pwr_state), .bank_open(bank_open), .illegal_cmd(illegal_cmd)
	);
	sbce_ctrl_model u_ctrl
	(
		.mclk(mclk), .clk_gate(clk_gate), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_enable_n(write_enable_n), .bank_select(bank_select), .addr(addr),
		.byte_mask(byte_mask), .dq_in(dq_in)
	);
	// each array word names its own bank, row and column, so order slips show
	assign arr_rdata = {arr_bank, arr_row[4:0], arr_col};
	always #5 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// wrap inside the aligned block of the burst length
	function automatic logic [8:0] col_of(input logic [8:0] c, input int bl, input logic v,
		input int k);
		logic [8:0] m;
		m = 9'(bl - 1);
		col_of = (c & ~m) | ((v ? (c ^ 9'(k)) : (c + 9'(k))) & m);
	endfunction
	task cmp16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked = samples_checked + 16'h1;
		if (got !== exp)
		begin
			fails = fails + 16'h1;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmp2(input logic [1:0] got, input logic [1:0] exp);
		samples_checked = samples_checked + 16'h1;
		if (got !== exp)
		begin
			fails = fails + 16'h1;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test();
		if (fails === 16'h0 && samples_checked > 16'h0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// read beats and array writes are matched in burst order
	always @(posedge mclk)
	begin
		if (dq_oe_n === 2'h0)
			cmp16(dq_out, (rd_q.size() > 0) ? rd_q.pop_front() : ~dq_out);
		if (arr_write === 1'b1)
		begin
			cmp16(arr_wdata, (wd_q.size() > 0) ? wd_q.pop_front() : ~arr_wdata);
			cmp16({7'h0, arr_col}, (wc_q.size() > 0) ? wc_q.pop_front() : 16'hFFFF);
		end
		if (illegal_cmd === 1'b1)
			illegal_seen <= illegal_seen + 16'h1;
	end
	// watchdog: 400 us, twice the 200 us power-on wait, well past the few microseconds of traffic
	initial
	begin
		#400000;
		fails = fails + 16'h1;
		stop_test();
	end
	initial
	begin
		mclk = 1'b0;
		reset = 1'b1;
		fails = 16'h0;
		samples_checked = 16'h0;
		illegal_seen = 16'h0;
		seed = 32'h1c99d1bc;
		seed = lfsr(seed);
		b = seed[1:0];
		r = seed[14:2];
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		// 200 us stable nop, close all, eight refreshes, then mode loads
		u_ctrl.nop(20000);
		u_ctrl.cmd(PRE, b, r | 13'h0400, 1'b1);
		u_ctrl.nop(3);
		repeat (8)
		begin
			u_ctrl.cmd(REF, b, r, 1'b1);
			u_ctrl.nop(7);
		end
		u_ctrl.mask(2'h0);
		for (int i = 0; i < 5; i++)
		begin
			seed = lfsr(seed);
			b = seed[1:0];
			r = seed[14:2];
			s = seed[31:23];
			// latency 2, loaded only with all banks idle
			u_ctrl.cmd(MODE, 2'h0, 13'h0020 | (13'(ilv_t[i]) << `SBCE_MODE_BT_BIT) | 13'(code_t[i]),
				1'b1);
			u_ctrl.nop(3);
			u_ctrl.cmd(ACT, b, r, 1'b1);
			u_ctrl.nop(3);
			cmp16({12'h0, bank_open}, 16'(1 << b));
			for (int k = 0; k < bl_t[i]; k++)
			begin
				seed = lfsr(seed);
				u_ctrl.wq.push_back(seed[15:0]);
				wd_q.push_back(seed[15:0]);
				wc_q.push_back({7'h0, col_of(s, bl_t[i], ilv_t[i], k)});
				rd_q.push_back({b, r[4:0], col_of(s, bl_t[i], ilv_t[i], k)});
			end
			u_ctrl.cmd(WR, b, {4'h0, s}, 1'b1);
			u_ctrl.nop(4);
			// odd passes close the bank by themselves after the burst
			u_ctrl.cmd(RD, b, {2'h0, i[0], 1'b0, s}, 1'b1);
			u_ctrl.nop(14);
			cmp16({12'h0, bank_open}, i[0] ? 16'h0 : 16'(1 << b));
			u_ctrl.cmd(PRE, b, r | 13'h0400, 1'b1);
			u_ctrl.nop(5);
			cmp16({12'h0, bank_open}, 16'h0);
		end
		// all banks are closed here, so any bank refuses the read
		u_ctrl.cmd(RD, b, r, 1'b1);
		u_ctrl.nop(6);
		cmp16(illegal_seen, 16'h1);
		u_ctrl.cmd(NOP, b, r, 1'b0);
		u_ctrl.nop(4);
		cmp2(pwr_state, SBCE_PWR_POWER_DOWN);
		u_ctrl.cmd(NOP, b, r, 1'b1);
		u_ctrl.nop(4);
		cmp2(pwr_state, SBCE_PWR_NORMAL);
		u_ctrl.cmd(REF, b, r, 1'b0);
		u_ctrl.nop(8);
		cmp2(pwr_state, SBCE_PWR_SELF_REFRESH);
		u_ctrl.cmd(NOP, b, r, 1'b1);
		u_ctrl.nop(14);
		cmp2(pwr_state, SBCE_PWR_NORMAL);
		cmp16(16'(rd_q.size() + wd_q.size() + wc_q.size()), 16'h0);
		stop_test();
	end
endmodule
